// [core/dis_regs.svh]
`ifndef DIS_REGS_SVH
`define DIS_REGS_SVH
`define DIS_ADDR_OUT_IMG 5'h00
`define DIS_ADDR_RESP_LO 5'h04
`define DIS_ADDR_RESP_HI 5'h08
`define DIS_ADDR_DIAG 5'h0c
`define DIS_ADDR_FAIL_CNT 5'h10
`define DIS_ADDR_IRQ_STAT 5'h14
`define DIS_ADDR_IRQ_MASK 5'h18
`define DIS_OUT_CH0 0
`define DIS_OUT_CH1 1
`define DIS_HI_SEAL0 3
`define DIS_HI_COIL0 4
`define DIS_HI_COIL1 5
`define DIS_HI_PWR0 6
`define DIS_HI_PWR1 7
`define DIS_DIAG_VOFF 0
`define DIS_IRQ_UPDATE 0
`define DIS_IRQ_VOFF 1
`define DIS_IRQ_FORCED 2
`define DIS_OUT_OFF_N 2'h3
`define DIS_FAIL_LIMIT 8'h0a
`define DIS_FAIL_MAX 8'hff
`define DIS_NUM_DIN 11
`define DIS_NUM_VOLT 3
`define DIS_SYNC_W 19
`define DIS_CLK_NS 40
`define DIS_SCAN_NS 10000
`define DIS_SCAN_CYC ((`DIS_SCAN_NS + `DIS_CLK_NS - 1) / `DIS_CLK_NS)
`endif

// [core/dis_pkg.sv]
`default_nettype none
`include "dis_regs.svh"
package dis_pkg;
	typedef enum logic {DIS_BUS_IDLE, DIS_BUS_ANSWER} dis_bus_t;

	typedef struct packed {
		dis_bus_t busState;
		logic waitReq;
		logic [31:0] readData;
		logic [7:0] scanCnt;
		logic scanTick;
		logic [15:0] image;
		logic [1:0] outImg;
		logic [1:0] outDriveN;
		logic diagErr;
		logic [2:0] irqStatus;
		logic [2:0] irqMask;
		logic irq;
	} dis_state_t;

	typedef struct packed {
		logic [`DIS_SYNC_W-1:0] meta;
		logic [`DIS_SYNC_W-1:0] stable;
	} dis_sync_state_t;

	typedef struct packed {
		logic [7:0] cnt;
	} dis_cnt_state_t;
endpackage
`default_nettype wire

// [core/dis_sync.sv]
`default_nettype none
`include "dis_regs.svh"
module dis_sync
(
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic [`DIS_SYNC_W-1:0] d, // raw pin levels
	output logic [`DIS_SYNC_W-1:0] q // synchronised levels
);
	import dis_pkg::*;

	dis_sync_state_t st;
	dis_sync_state_t next_st;

	always_comb
	begin
		next_st.meta = d;
		next_st.stable = st.meta;
	end

	// idle pins read high (inactive)
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '1;
		else
			st <= next_st;
	end

	assign q = st.stable;
endmodule
`default_nettype wire

// [core/dis_fail_counter.sv]
`default_nettype none
`include "dis_regs.svh"
module dis_fail_counter
#(
	parameter logic [7:0] LIMIT = `DIS_FAIL_LIMIT
)
(
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic tick, // one scan cycle
	input wire logic clear, // some interrogation voltage present
	output logic [7:0] count, // failed scans so far
	output logic over // count beyond limit
);
	import dis_pkg::*;

	dis_cnt_state_t st;
	dis_cnt_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (tick)
		begin
			if (clear)
				next_st.cnt = 8'h00; // R7
			else if (st.cnt != `DIS_FAIL_MAX) // R14
				next_st.cnt = st.cnt + 8'h01; // R5
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign count = st.cnt;
	assign over = (st.cnt > LIMIT); // R6
endmodule
`default_nettype wire

// [core/dis_scan.sv]
// Notes on behaviour
// R1: each scan samples voltages and both input bytes
// R2: update image only with some voltage present
// R3: any missing voltage sets diagnostic error bit
// R4: diagnostic byte readable by the controller
// R5: count scans with all voltages missing
// R6: beyond limit, update image regardless of voltage
// R7: counter held zero while any voltage present
// R8: coil continuity reads true while output on
// R9: output image byte written into output latch
// R10: output byte bit0 channel 0, bit1 channel 1
// R11: response byte one holds inputs 1 to 8
// R12: byte two: inputs 9-11, seal, coils, power
// R13: all sampled status lines are active low
// R14: limit is parameter, counter saturates
// R15: reset clears image, counter, error, outputs off
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`default_nettype none
`include "dis_regs.svh"
module dis_scan
#(
	parameter logic [7:0] FAIL_LIMIT = `DIS_FAIL_LIMIT
)
(
	input wire logic clk, // 25 MHz clock
	input wire logic rst, // async reset, high
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic irq, // level interrupt
	input wire logic [`DIS_NUM_DIN-1:0] dinN, // general inputs 1..11
	input wire logic [`DIS_NUM_VOLT-1:0] interrogationVoltOkN, // voltage status
	input wire logic coil0ContinuityN, // coil 0 present
	input wire logic coil1ContinuityN, // coil 1 present
	input wire logic power0PresentN, // power channel 0
	input wire logic power1PresentN, // power channel 1
	input wire logic sealin0StatusN, // seal-in channel 0
	output logic out0DriveN, // channel 0 drive
	output logic out1DriveN // channel 1 drive
);
	import dis_pkg::*;

	dis_state_t st;
	dis_state_t next_st;
	logic [`DIS_SYNC_W-1:0] pinsN;
	logic [`DIS_SYNC_W-1:0] syncN;
	logic [`DIS_SYNC_W-1:0] trueLv;
	logic [`DIS_NUM_VOLT-1:0] voltTrue;
	logic anyPresent;
	logic anyFalse;
	logic [7:0] failCount;
	logic failOver;
	logic [2:0] ev;

	function automatic logic [7:0] mask_coil(input logic [7:0] hi, input logic [1:0] outOn);
		logic [7:0] r;
		r = hi;
		r[`DIS_HI_COIL0] = hi[`DIS_HI_COIL0] | outOn[`DIS_OUT_CH0]; // R8
		r[`DIS_HI_COIL1] = hi[`DIS_HI_COIL1] | outOn[`DIS_OUT_CH1]; // R8
		return r;
	endfunction

	function automatic logic [31:0] read_mux(
		input logic [4:0] addr,
		input dis_state_t s,
		input logic [2:0] volt,
		input logic [7:0] fails
	);
		logic [31:0] r;
		r = 32'h0;
		case (addr)
			`DIS_ADDR_OUT_IMG: r[1:0] = s.outImg;
			`DIS_ADDR_RESP_LO: r[7:0] = s.image[7:0];
			`DIS_ADDR_RESP_HI: r[7:0] = mask_coil(s.image[15:8], s.outImg);
			`DIS_ADDR_DIAG: r[3:0] = {volt, s.diagErr};
			`DIS_ADDR_FAIL_CNT: r[7:0] = fails;
			`DIS_ADDR_IRQ_STAT: r[2:0] = s.irqStatus;
			`DIS_ADDR_IRQ_MASK: r[2:0] = s.irqMask;
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// bit order gives image = {hi byte, lo byte} directly
	assign pinsN = {power1PresentN, power0PresentN, coil1ContinuityN, coil0ContinuityN,
		sealin0StatusN, dinN, interrogationVoltOkN};

	dis_sync u_sync
	(
		.clk(clk),
		.rst(rst),
		.d(pinsN),
		.q(syncN)
	);

	assign trueLv = ~syncN; // R13
	assign voltTrue = trueLv[`DIS_NUM_VOLT-1:0];
	assign anyPresent = |voltTrue;
	assign anyFalse = ~&voltTrue;

	dis_fail_counter #(.LIMIT(FAIL_LIMIT)) u_fail
	(
		.clk(clk),
		.rst(rst),
		.tick(st.scanTick),
		.clear(anyPresent),
		.count(failCount),
		.over(failOver)
	);

	always_comb
	begin
		next_st = st;
		ev = 3'h0;
		next_st.scanTick = 1'b0;
		if (st.scanCnt == 8'(`DIS_SCAN_CYC - 1))
		begin
			next_st.scanCnt = 8'h00;
			next_st.scanTick = 1'b1;
		end
		else
			next_st.scanCnt = st.scanCnt + 8'h01;

		case (st.busState)
			DIS_BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					next_st.waitReq = 1'b0;
					next_st.busState = DIS_BUS_ANSWER;
					next_st.readData = avs_read ?
						read_mux(avs_address, st, voltTrue, failCount) : 32'h0;
				end
			end
			DIS_BUS_ANSWER:
			begin
				next_st.waitReq = 1'b1;
				next_st.busState = DIS_BUS_IDLE;
				if (avs_write && avs_byteenable[0])
				begin
					if (avs_address == `DIS_ADDR_OUT_IMG)
					begin
						next_st.outImg = avs_writedata[1:0]; // R9 R10
						next_st.outDriveN = ~avs_writedata[1:0]; // R9
					end
					if (avs_address == `DIS_ADDR_IRQ_MASK)
						next_st.irqMask = avs_writedata[2:0];
				end
				// clear only what the read actually returned
				if (avs_read && avs_address == `DIS_ADDR_IRQ_STAT)
					next_st.irqStatus = st.irqStatus & ~st.readData[2:0];
				if (avs_read && avs_address == `DIS_ADDR_DIAG
					&& st.readData[`DIS_DIAG_VOFF])
					next_st.diagErr = 1'b0; // R4
			end
			default:
			begin
				next_st.busState = DIS_BUS_IDLE;
				next_st.waitReq = 1'b1;
			end
		endcase

		if (st.scanTick) // R1
		begin
			if (anyPresent || failOver) // R2 R6
			begin
				next_st.image = trueLv[`DIS_SYNC_W-1:`DIS_NUM_VOLT]; // R11 R12
				ev[`DIS_IRQ_UPDATE] = 1'b1;
				ev[`DIS_IRQ_FORCED] = ~anyPresent; // R6
			end
			if (anyFalse)
			begin
				ev[`DIS_IRQ_VOFF] = ~st.diagErr;
				next_st.diagErr = 1'b1; // R3
			end
		end
		// events win over a same-cycle clear
		next_st.irqStatus = next_st.irqStatus | ev;
		next_st.irq = |(next_st.irqStatus & next_st.irqMask);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0; // R15
			st.busState <= DIS_BUS_IDLE;
			st.waitReq <= 1'b1;
			st.outDriveN <= `DIS_OUT_OFF_N; // R15
		end
		else
			st <= next_st;
	end

	assign avs_readdata = st.readData;
	assign avs_waitrequest = st.waitReq;
	assign irq = st.irq;
	assign out0DriveN = st.outDriveN[`DIS_OUT_CH0];
	assign out1DriveN = st.outDriveN[`DIS_OUT_CH1];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_req_seen;
		(avs_read || avs_write) && st.waitReq;
	endsequence

	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	property p_bus_answer;
		s_req_seen |=> s_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("waitrequest did not drop for exactly one cycle");

	property p_fail_zero;
		st.scanTick && anyPresent |=> failCount == 8'h00;
	endproperty
	a_fail_zero: assert property (p_fail_zero) // R7
		else $error("fail counter not held at zero with voltage present");

	property p_fail_inc;
		st.scanTick && !anyPresent && failCount != `DIS_FAIL_MAX
			|=> failCount == $past(failCount) + 8'h01;
	endproperty
	a_fail_inc: assert property (p_fail_inc) // R5
		else $error("fail counter did not step on a dead scan");

	property p_fail_sat;
		failCount == `DIS_FAIL_MAX && !(st.scanTick && anyPresent)
			|=> failCount == `DIS_FAIL_MAX;
	endproperty
	a_fail_sat: assert property (p_fail_sat) // R14
		else $error("fail counter wrapped");

	property p_hold;
		st.scanTick && !anyPresent && !failOver |=> $stable(st.image);
	endproperty
	a_hold: assert property (p_hold) // R2
		else $error("image changed with no voltage and no override");

	property p_update;
		st.scanTick && (anyPresent || failOver)
			|=> st.image == ~$past(syncN[`DIS_SYNC_W-1:`DIS_NUM_VOLT]);
	endproperty
	a_update: assert property (p_update) // R1
		else $error("image not refreshed from inverted pins");

	property p_force;
		st.scanTick && !anyPresent && failOver |=> st.irqStatus[`DIS_IRQ_FORCED];
	endproperty
	a_force: assert property (p_force) // R6
		else $error("forced update not flagged");

	property p_diag;
		st.scanTick && anyFalse |=> st.diagErr ##1 $past(st.diagErr);
	endproperty
	a_diag: assert property (p_diag) // R3
		else $error("voltage-off error bit not set");

	property p_latch;
		avs_write && !avs_waitrequest && avs_byteenable[0]
			&& avs_address == `DIS_ADDR_OUT_IMG
			|=> {out1DriveN, out0DriveN} == ~$past(avs_writedata[1:0]);
	endproperty
	a_latch: assert property (p_latch) // R9
		else $error("output latch not loaded from poll byte");

	property p_coil;
		avs_read && st.waitReq && avs_address == `DIS_ADDR_RESP_HI
			&& !out0DriveN |=> avs_readdata[`DIS_HI_COIL0];
	endproperty
	a_coil: assert property (p_coil) // R8
		else $error("coil continuity not forced true with output on");

	property p_irq_level;
		irq == |(st.irqStatus & st.irqMask);
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt level disagrees with status and mask");

	property p_tick;
		st.scanCnt == 8'(`DIS_SCAN_CYC - 1) |=> st.scanTick;
	endproperty
	a_tick: assert property (p_tick) // R1
		else $error("scan tick missing at end of period");

	property p_fail_idle;
		!st.scanTick |=> $stable(failCount);
	endproperty
	a_fail_idle: assert property (p_fail_idle) // R5
		else $error("fail counter moved between scans");

	property p_image_quiet;
		!st.scanTick |=> $stable(st.image);
	endproperty
	a_image_quiet: assert property (p_image_quiet) // R2
		else $error("image changed between scans");

	property p_resp_lo;
		avs_read && st.waitReq && avs_address == `DIS_ADDR_RESP_LO
			|=> avs_readdata == {24'h0, $past(st.image[7:0])};
	endproperty
	a_resp_lo: assert property (p_resp_lo) // R11
		else $error("response low byte not the input image");

	property p_resp_hi;
		avs_read && st.waitReq && avs_address == `DIS_ADDR_RESP_HI
			|=> avs_readdata[3:0] == $past(st.image[11:8])
			&& avs_readdata[7:6] == $past(st.image[15:14]);
	endproperty
	a_resp_hi: assert property (p_resp_hi) // R12
		else $error("response high byte fields misplaced");

	property p_coil_off;
		avs_read && st.waitReq && avs_address == `DIS_ADDR_RESP_HI && out0DriveN
			|=> avs_readdata[`DIS_HI_COIL0] == $past(st.image[8 + `DIS_HI_COIL0]);
	endproperty
	a_coil_off: assert property (p_coil_off) // R8
		else $error("coil continuity masked with output off");

	property p_coil1;
		avs_read && st.waitReq && avs_address == `DIS_ADDR_RESP_HI
			&& !out1DriveN |=> avs_readdata[`DIS_HI_COIL1];
	endproperty
	a_coil1: assert property (p_coil1) // R8
		else $error("coil 1 continuity not forced true with output on");

	property p_latch_ignore;
		avs_write && !avs_waitrequest && !avs_byteenable[0]
			|=> $stable({out1DriveN, out0DriveN});
	endproperty
	a_latch_ignore: assert property (p_latch_ignore) // R9
		else $error("output latch changed on a disabled lane");

	property p_latch_hold;
		!(avs_write && !avs_waitrequest) |=> $stable({out1DriveN, out0DriveN});
	endproperty
	a_latch_hold: assert property (p_latch_hold) // R9
		else $error("output latch changed with no write");

	property p_diag_read;
		avs_read && st.waitReq && avs_address == `DIS_ADDR_DIAG
			|=> avs_readdata[`DIS_DIAG_VOFF] == $past(st.diagErr);
	endproperty
	a_diag_read: assert property (p_diag_read) // R4
		else $error("diagnostic byte lost the voltage-off bit");

	property p_voff_irq;
		st.scanTick && anyFalse && !st.diagErr |=> st.irqStatus[`DIS_IRQ_VOFF];
	endproperty
	a_voff_irq: assert property (p_voff_irq) // R3
		else $error("voltage-off event not flagged");
endmodule
`default_nettype wire

// [tb/dis_ctl_model.sv]
`default_nettype none
module dis_ctl_model
(
	input wire logic clk, // bus clock
	input wire logic [31:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // stall
	output logic [4:0] avs_address, // byte address
	output logic avs_read, // read request
	output logic avs_write, // write request
	output logic [31:0] avs_writedata, // write data
	output logic [3:0] avs_byteenable // byte lanes
);
	timeunit 1ns;
	timeprecision 1ns;
	int hung = 0;
	initial
	begin
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end
	// one transfer, held until waitrequest is seen low
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		q = 32'h0;
		@(posedge clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= d;
		avs_byteenable <= be;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			hung++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
`include "dis_regs.svh"
module tb;
	import dis_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, irq, out0N, out1N;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [10:0] dinN = 11'h7ff;
	logic [2:0] voltN = 3'h0;
	logic coil0N = 1'b1, coil1N = 1'b1, pwr0N = 1'b1, pwr1N = 1'b1, sealN = 1'b1;
	int miscompares = 0;
	int checks = 0;
	logic [31:0] lfsr = 32'hc1ab;
	logic [15:0] raw = 16'h0, img = 16'h0;
	logic [1:0] outImg = 2'h0;
	logic [4:0] regs[6] = '{`DIS_ADDR_OUT_IMG, `DIS_ADDR_RESP_LO, `DIS_ADDR_RESP_HI,
		`DIS_ADDR_FAIL_CNT, `DIS_ADDR_IRQ_STAT, `DIS_ADDR_IRQ_MASK};

	dis_scan #(.FAIL_LIMIT(8'h02)) uut
	(
		.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .dinN(dinN),
		.interrogationVoltOkN(voltN), .coil0ContinuityN(coil0N),
		.coil1ContinuityN(coil1N), .power0PresentN(pwr0N), .power1PresentN(pwr1N),
		.sealin0StatusN(sealN), .out0DriveN(out0N), .out1DriveN(out1N)
	);
	dis_ctl_model ctl
	(
		.clk(clk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable)
	);

	initial
		forever #20 clk = ~clk;

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic end_sim();
		miscompares += ctl.hung;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
		logic [31:0] q;
		ctl.xfer(1'b0, a, 32'h0, 4'hf, q);
		chk(q & m, exp);
		if (ctl.hung != 0)
			end_sim();
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		ctl.xfer(1'b1, a, d, be, q);
		if (ctl.hung != 0)
			end_sim();
	endtask
	// new random pins; model keeps true levels
	task automatic drive(input logic [2:0] v);
		lfsr = nxt(lfsr);
		@(posedge clk);
		voltN <= v;
		{pwr1N, pwr0N, coil1N, coil0N, sealN, dinN} <= lfsr[15:0];
		raw = ~lfsr[15:0];
	endtask
	task automatic settle();
		repeat (270) @(posedge clk);
	endtask
	task automatic cmpImg();
		rd(`DIS_ADDR_RESP_LO, {24'h0, img[7:0]});
		rd(`DIS_ADDR_RESP_HI, {24'h0, img[15:8] | {2'h0, outImg, 4'h0}});
	endtask
	task automatic waitCnt(input int n);
		logic [31:0] q;
		int k;
		k = 0;
		q = 32'h0;
		while (q !== n && k < 300)
		begin
			ctl.xfer(1'b0, `DIS_ADDR_FAIL_CNT, 32'h0, 4'hf, q);
			k++;
		end
		chk(q, n);
		if (k >= 300)
			end_sim();
	endtask

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk({30'h0, out1N, out0N}, 32'h3);
		foreach (regs[i])
			rd(regs[i], 32'h0);
		repeat (8)
		begin
			drive(3'h0);
			lfsr = nxt(lfsr);
			if (lfsr[4])
				outImg = lfsr[1:0];
			wr(`DIS_ADDR_OUT_IMG, lfsr, lfsr[7:4]);
			settle();
			img = raw;
			cmpImg();
			chk({30'h0, out1N, out0N}, {30'h0, ~outImg});
		end
		rd(`DIS_ADDR_DIAG, 32'he);
		for (int v = 0; v < 3; v++)
		begin
			drive(3'h1 << v);
			settle();
			img = raw;
			cmpImg();
			rd(`DIS_ADDR_FAIL_CNT, 32'h0);
			rd(`DIS_ADDR_DIAG, {28'h0, ~(3'h1 << v), 1'b1});
		end
		drive(3'h0);
		settle();
		img = raw;
		rd(`DIS_ADDR_DIAG, 32'he, 32'he);
		rd(`DIS_ADDR_DIAG, 32'he);
		drive(3'h7);
		waitCnt(1);
		cmpImg();
		waitCnt(3);
		cmpImg();
		waitCnt(4);
		img = raw;
		cmpImg();
		repeat (65000) @(posedge clk);
		rd(`DIS_ADDR_FAIL_CNT, 32'hff);
		rd(`DIS_ADDR_IRQ_STAT, 32'h4, 32'h4);
		drive(3'h0);
		settle();
		rd(`DIS_ADDR_FAIL_CNT, 32'h0);
		rd(`DIS_ADDR_IRQ_STAT, 32'h1, 32'h1);
		wr(`DIS_ADDR_IRQ_MASK, 32'h1, 4'h1);
		rd(`DIS_ADDR_IRQ_MASK, 32'h1);
		settle();
		chk({31'h0, irq}, 32'h1);
		wr(`DIS_ADDR_IRQ_MASK, 32'h0, 4'h1);
		repeat (2) @(negedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(5'h1c, 32'h0);
		wr(5'h1c, 32'hffffffff, 4'hf);
		rd(`DIS_ADDR_OUT_IMG, {30'h0, outImg});
		end_sim();
	end
endmodule
`default_nettype wire
